// ===== src/ptu_pulse_timing_unit.sv
`timescale 1ns/1ps
// What this block does
// - counting mode counts whole pulses on pin over a window of given milliseconds
// - pulse-width measurement turns the pin to input first
// - if pin already at level, wait for opposite level before timing
// - pulse width returns zero after one second waiting or at level
// - pulse widths reported in microseconds, resolving one microsecond
// - pulse emit drives inverted level for given microseconds, then restores
// - emitted pulses may be as short as one microsecond
// - eight-bit duty, 255 means always high, lower values proportional
// - pwm drives pin for given milliseconds, then tristates it
// - level duration times pin at level from start, in microseconds
// - level duration returns one at once if pin not at level
// - level duration returns zero after one second at level
module ptu_pulse_timing_unit (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // command
  input  wire logic        start_in,
  input  wire logic [2:0]  op_in,
  input  wire logic        level_in,
  input  wire logic [7:0]  duty_in,
  input  wire logic [31:0] amount_in,
  // result
  output logic             busy_out,
  output logic             done_out,
  output logic [31:0]      result_out,
  // pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n_out
);
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    ST_IDLE, ST_COUNT, ST_PW_ARM, ST_PW_WAIT, ST_PW_TIME,
    ST_EMIT, ST_PWM, ST_LVL
  } ptu_state_t;

  ptu_state_t  state_reg;
  logic        sync1_reg, sync2_reg, prev_reg;
  logic [6:0]  div_reg;
  logic [9:0]  ms_div_reg;
  logic        us_tick, ms_tick;
  logic [31:0] time_reg;
  logic [31:0] cnt_reg;
  logic [31:0] amount_reg;
  logic        level_reg;
  logic [7:0]  duty_reg;
  logic [7:0]  phase_reg;
  logic        pulse_half_reg;
  logic        rise, fall;
  logic        start_take;

  // a command is taken only while idle
  assign start_take = (state_reg == ST_IDLE) && start_in;

  // ==========================================================
  // pin synchroniser; stage two and its delayed copy prev_reg are looked at
  // two-flop sync
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // ==========================================================
  // microsecond and millisecond ticks, restarted by each taken command
  // derived time base
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_reg    <= 7'h00;
      ms_div_reg <= 10'h000;
    end else if (start_take) begin
      // restart so the first tick is a whole microsecond, never a sliver
      div_reg    <= 7'h00;
      ms_div_reg <= 10'h000;
    end else begin
      div_reg <= (div_reg == ptu_pkg::TICK_DIV_LAST) ? 7'h00
                 : div_reg + 7'h01;
      if (us_tick)
        ms_div_reg <= (ms_div_reg == ptu_pkg::MS_DIV_LAST) ? 10'h000
                      : ms_div_reg + 10'h001;
    end
  end
  assign us_tick = (div_reg == ptu_pkg::TICK_DIV_LAST);
  assign ms_tick = us_tick && (ms_div_reg == ptu_pkg::MS_DIV_LAST);

  // ==========================================================
  // main sequencer; time_reg counts ticks, cnt_reg results
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg      <= ST_IDLE;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      result_out     <= ptu_pkg::RESULT_ZERO;
      pin_out        <= 1'b0;
      pin_oe_n_out   <= 1'b1;
      time_reg       <= 32'h0000_0000;
      cnt_reg        <= 32'h0000_0000;
      amount_reg     <= 32'h0000_0000;
      level_reg      <= 1'b0;
      duty_reg       <= 8'h00;
      phase_reg      <= 8'h00;
      pulse_half_reg <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start_in) begin
            busy_out       <= 1'b1;
            amount_reg     <= amount_in;
            level_reg      <= level_in;
            duty_reg       <= duty_in;
            time_reg       <= 32'h0000_0000;
            cnt_reg        <= 32'h0000_0000;
            phase_reg      <= 8'h00;
            pulse_half_reg <= 1'b0;
            unique case (op_in)
              // observing ops let go of the pin so they never see themselves
              3'(ptu_pkg::PTU_OP_COUNT): begin
                pin_oe_n_out <= 1'b1;
                state_reg    <= ST_COUNT;
              end
              3'(ptu_pkg::PTU_OP_PULSE_WIDTH): begin
                pin_oe_n_out <= 1'b1;
                state_reg    <= ST_PW_ARM;
              end
              3'(ptu_pkg::PTU_OP_PULSE_EMIT): begin
                pin_out      <= ~sync2_reg;
                pin_oe_n_out <= 1'b0;
                state_reg    <= ST_EMIT;
              end
              3'(ptu_pkg::PTU_OP_PWM): begin
                pin_oe_n_out <= 1'b0;
                state_reg    <= ST_PWM;
              end
              3'(ptu_pkg::PTU_OP_LEVEL_DUR): begin
                pin_oe_n_out <= 1'b1;
                state_reg    <= ST_LVL;
              end
              default: begin
                busy_out  <= 1'b0;
                done_out  <= 1'b1;
                result_out <= ptu_pkg::RESULT_ZERO;
              end
            endcase
          end
        end
        ST_COUNT: begin
          if (pulse_half_reg == 1'b0 && (rise || fall)) begin
            pulse_half_reg <= 1'b1;
            level_reg      <= rise;
          end else if (pulse_half_reg && (rise || fall)) begin
            // a pulse closes when the pin returns to its starting side
            if ((rise && !level_reg) || (fall && level_reg)) begin
              cnt_reg        <= cnt_reg + 32'h0000_0001;
              pulse_half_reg <= 1'b0;
            end else begin
              level_reg <= rise;
            end
          end
          if (ms_tick)
            time_reg <= time_reg + 32'h0000_0001;
          if (time_reg >= amount_reg) begin
            result_out <= cnt_reg;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_PW_ARM: begin
          if (us_tick)
            time_reg <= time_reg + 32'h0000_0001;
          if (sync2_reg != level_reg) begin
            state_reg <= ST_PW_WAIT;
          end else if (time_reg >= ptu_pkg::TIMEOUT_US_W) begin
            result_out <= ptu_pkg::RESULT_ZERO;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_PW_WAIT: begin
          if (us_tick)
            time_reg <= time_reg + 32'h0000_0001;
          if (sync2_reg == level_reg) begin
            cnt_reg   <= 32'h0000_0000;
            state_reg <= ST_PW_TIME;
          end else if (time_reg >= ptu_pkg::TIMEOUT_US_W) begin
            result_out <= ptu_pkg::RESULT_ZERO;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_PW_TIME: begin
          if (us_tick)
            cnt_reg <= cnt_reg + 32'h0000_0001;
          if (sync2_reg != level_reg || cnt_reg > ptu_pkg::TIMEOUT_US_W) begin
            result_out <= (cnt_reg > ptu_pkg::TIMEOUT_US_W)
                          ? ptu_pkg::RESULT_ZERO : cnt_reg;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_EMIT: begin
          if (us_tick)
            time_reg <= time_reg + 32'h0000_0001;
          if (time_reg >= amount_reg) begin
            pin_out   <= ~pin_out;
            busy_out  <= 1'b0;
            done_out  <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_PWM: begin
          phase_reg <= (phase_reg == ptu_pkg::DUTY_LAST) ? 8'h00
                       : phase_reg + 8'h01;
          pin_out   <= (duty_reg == ptu_pkg::DUTY_FULL)
                       || (phase_reg < duty_reg);
          if (ms_tick)
            time_reg <= time_reg + 32'h0000_0001;
          if (time_reg >= amount_reg) begin
            pin_oe_n_out <= 1'b1;
            pin_out      <= 1'b0;
            busy_out     <= 1'b0;
            done_out     <= 1'b1;
            state_reg    <= ST_IDLE;
          end
        end
        ST_LVL: begin
          if (us_tick)
            cnt_reg <= cnt_reg + 32'h0000_0001;
          if (sync2_reg != level_reg) begin
            result_out <= (cnt_reg == 32'h0000_0000)
                          ? ptu_pkg::RESULT_NOT_LVL : cnt_reg;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
            state_reg  <= ST_IDLE;
          end else if (cnt_reg > ptu_pkg::TIMEOUT_US_W) begin
            result_out <= ptu_pkg::RESULT_ZERO;
            busy_out   <= 1'b0;
            done_out   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== src/ptu_pkg.sv
package ptu_pkg;
  // ==========================================================
  // clock and time base
  localparam int          CLK_MHZ         = 125;
  localparam int          TICK_US_CYC     = CLK_MHZ;
  localparam int          US_PER_MS       = 1000;
  localparam int          TIMEOUT_S       = 1;
  localparam int          TIMEOUT_US      = TIMEOUT_S * 1000000;
  localparam logic [6:0]  TICK_DIV_LAST   = 7'(TICK_US_CYC - 1);
  localparam logic [9:0]  MS_DIV_LAST     = 10'(US_PER_MS - 1);
  localparam logic [31:0] TIMEOUT_US_W    = 32'(TIMEOUT_US);
  // ==========================================================
  // pwm period and result codes
  localparam logic [7:0]  DUTY_FULL       = 8'hFF;
  // pwm period is 255 clocks, so only duty 255 stays high all period
  localparam logic [7:0]  DUTY_LAST       = 8'hFE;
  localparam logic [31:0] RESULT_ZERO     = 32'h0000_0000;
  localparam logic [31:0] RESULT_NOT_LVL  = 32'h0000_0001;
  // ==========================================================
  // operation selector
  typedef enum logic [2:0] {
    PTU_OP_COUNT,
    PTU_OP_PULSE_WIDTH,
    PTU_OP_PULSE_EMIT,
    PTU_OP_PWM,
    PTU_OP_LEVEL_DUR
  } ptu_op_t;
endpackage

// ===== verification/ptu_src_model.sv
`timescale 1ns/1ps
// ======
// far-side source: holds the pin whenever the block lets go of it
module ptu_src (
  // block side
  input  wire logic drv_in,
  input  wire logic oe_n_in,
  // level the source wants
  input  wire logic lvl_in,
  // resolved pin
  output logic      wire_out
);
  // a real source would fight the block; here the block simply wins
  assign wire_out = oe_n_in ? lvl_in : drv_in;
endmodule

// ===== verification/ptu_pulse_timing_unit_chk.sv
`timescale 1ns/1ps
module ptu_chk (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  // command
  input wire logic        start_in,
  input wire logic [2:0]  op_in,
  input wire logic        level_in,
  input wire logic [7:0]  duty_in,
  input wire logic [31:0] amount_in,
  // result
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic [31:0] result_out,
  // pin
  input wire logic        pin_in,
  input wire logic        pin_out,
  input wire logic        pin_oe_n_out
);
  localparam logic [2:0] EMIT = ptu_pkg::PTU_OP_PULSE_EMIT;
  localparam logic [2:0] PW   = ptu_pkg::PTU_OP_PULSE_WIDTH;
  localparam logic [2:0] PWM  = ptu_pkg::PTU_OP_PWM;
  localparam logic [2:0] LVL  = ptu_pkg::PTU_OP_LEVEL_DUR;
  logic       take;
  logic [2:0] op_reg;
  logic [7:0] duty_reg;
  assign take = start_in && !busy_out;
  // op_in may move once taken, so keep our own copy
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      op_reg   <= 3'h0;
      duty_reg <= 8'h00;
    end else if (take) begin
      op_reg   <= op_in;
      duty_reg <= duty_in;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  property p_emit_drv;
    take && op_in == EMIT && amount_in != 0 |=> busy_out && !pin_oe_n_out;
  endproperty
  a_emit_drv: assert property (p_emit_drv)
    else $error("emit did not take the pin");
  property p_emit_len;
    take && op_in == EMIT && amount_in == 32'h1
      |=> !done_out [*8] ##[110:252] done_out;
  endproperty
  a_emit_len: assert property (p_emit_len)
    else $error("one microsecond pulse has wrong length");
  property p_pw_in; busy_out && op_reg == PW |-> pin_oe_n_out; endproperty
  a_pw_in: assert property (p_pw_in)
    else $error("pin driven during width measure");
  property p_pwm_full;
    busy_out && $past(busy_out) && op_reg == PWM && duty_reg == 8'hFF
      && !pin_oe_n_out |-> pin_out;
  endproperty
  a_pwm_full: assert property (p_pwm_full)
    else $error("full duty output went low");
  property p_pwm_rel;
    done_out && op_reg == PWM |-> ##[0:2] pin_oe_n_out;
  endproperty
  a_pwm_rel: assert property (p_pwm_rel)
    else $error("pin not released after pwm");
  property p_lvl_off;
    (pin_in != level_in) [*4] ##0 (take && op_in == LVL)
      |-> ##[1:8] (done_out && result_out == 32'h1);
  endproperty
  a_lvl_off: assert property (p_lvl_off)
    else $error("off-level start did not return one");
  property p_done_one; done_out |=> !done_out; endproperty
  a_done_one: assert property (p_done_one)
    else $error("done longer than one cycle");
  property p_res_hold; !done_out |-> $stable(result_out); endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result moved without done");
  c_pwm: cover property (done_out && op_reg == PWM);
  c_emit: cover property (done_out && op_reg == EMIT);
  c_one: cover property (done_out && result_out == 32'h1);
endmodule
bind ptu_pulse_timing_unit ptu_chk ptu_chk_i (
  .clk_sys_in   (clk_sys_in),
  .reset_n_in   (reset_n_in),
  .start_in     (start_in),
  .op_in        (op_in),
  .level_in     (level_in),
  .duty_in      (duty_in),
  .amount_in    (amount_in),
  .busy_out     (busy_out),
  .done_out     (done_out),
  .result_out   (result_out),
  .pin_in       (pin_in),
  .pin_out      (pin_out),
  .pin_oe_n_out (pin_oe_n_out)
);

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  // ======
  // design hookup
  logic        clk_sys_in, reset_n_in, start_in, level_in, src_lvl;
  logic [2:0]  op_in;
  logic [7:0]  duty_in;
  logic [31:0] amount_in, result_out;
  logic        busy_out, done_out, pin_in, pin_out, pin_oe_n_out;
  logic [31:0] lo_q[$], hi_q[$];
  int          num_errors, num_checks, n, i;
  ptu_pulse_timing_unit ptu_pulse_timing_unit_i (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .start_in(start_in),
    .op_in(op_in), .level_in(level_in), .duty_in(duty_in),
    .amount_in(amount_in), .busy_out(busy_out), .done_out(done_out),
    .result_out(result_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out));
  ptu_src ptu_src_i (.drv_in(pin_out), .oe_n_in(pin_oe_n_out),
    .lvl_in(src_lvl), .wire_out(pin_in));
  // 125 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task us(input int k);
    repeat (k * ptu_pkg::TICK_US_CYC) @(negedge clk_sys_in);
  endtask
  // ======
  // start an op and note the range its result must fall in
  task go(input logic [2:0] op, input logic [31:0] amt, lo, hi);
    @(negedge clk_sys_in);
    op_in = op;
    amount_in = amt;
    start_in = 1'b1;
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    @(negedge clk_sys_in);
    start_in = 1'b0;
  endtask
  // bounded wait for the monitor to consume the note
  task fin;
    repeat (200000) if (lo_q.size() != 0) @(negedge clk_sys_in);
    repeat (3) @(negedge clk_sys_in);
    $display("test op %0d over", op_in);
  endtask
  // results come back in start order, so the oldest note applies
  always @(negedge clk_sys_in) begin
    if (done_out === 1'b1) begin
      chk({31'h0, result_out >= lo_q[0] && result_out <= hi_q[0]}, 1);
      void'(lo_q.pop_front());
      void'(hi_q.pop_front());
    end
  end
  initial begin
    {start_in, level_in, src_lvl, op_in, duty_in, amount_in} = '0;
    reset_n_in = 1'b0;
    num_errors = 0;
    num_checks = 0;
    n = $urandom(32'h8bcfa52f);
    repeat (8) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    // unknown op finishes at once with zero
    go(3'h7, 32'h0, 32'h0, 32'h0);
    fin;
    // emit from both idle levels, shortest length first; an off-level
    // duration request hands the pin back to the source beforehand
    for (i = 0; i < 2; i++) begin
      src_lvl = i[0];
      level_in = 1'b1;
      go(ptu_pkg::PTU_OP_LEVEL_DUR, 32'h0, 32'h1, 32'h1);
      fin;
      n = (i == 0) ? 1 : $urandom_range(5, 2);
      go(ptu_pkg::PTU_OP_PULSE_EMIT, 32'(n), 32'h0, '1);
      repeat (2) @(negedge clk_sys_in);
      chk(32'(pin_in), 32'(!i[0]));
      fin;
      chk(32'(pin_in), 32'(i[0]));
    end
    // level duration, first off level, then held n us
    src_lvl = 1'b1;
    level_in = 1'b0;
    go(ptu_pkg::PTU_OP_LEVEL_DUR, 32'h0, 32'h1, 32'h1);
    fin;
    level_in = 1'b1;
    n = $urandom_range(9, 3);
    go(ptu_pkg::PTU_OP_LEVEL_DUR, 32'h0, 32'(n - 1), 32'(n + 1));
    us(n);
    src_lvl = 1'b0;
    fin;
    // width: first phase longer than any n, so it must be skipped
    src_lvl = 1'b1;
    go(ptu_pkg::PTU_OP_PULSE_WIDTH, 32'h0, 32'(n - 1), 32'(n + 1));
    us(12);
    src_lvl = 1'b0;
    us(2);
    src_lvl = 1'b1;
    us(n);
    src_lvl = 1'b0;
    fin;
    // count n whole pulses in a 1 ms window
    n = $urandom_range(4, 1);
    go(ptu_pkg::PTU_OP_COUNT, 32'h1, 32'(n), 32'(n));
    us(5);
    repeat (n) begin
      src_lvl = 1'b1;
      us(10);
      src_lvl = 1'b0;
      us(10);
    end
    fin;
    // pwm at the duty extremes, source parked at the opposite level; the
    // first train is cut by a reset after 100 us to save 900 us
    for (i = 0; i < 2; i++) begin
      duty_in = i[0] ? 8'hFF : 8'h00;
      src_lvl = !i[0];
      go(ptu_pkg::PTU_OP_PWM, 32'h1, 32'h0, '1);
      us(100);
      chk(32'(pin_in), 32'(i[0]));
      if (i == 0) begin
        reset_n_in = 1'b0;
        void'(lo_q.pop_front());
        void'(hi_q.pop_front());
        repeat (2) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        $display("test op %0d cut by reset", op_in);
      end else begin
        fin;
      end
      chk(32'(pin_oe_n_out), 32'h1);
    end
    chk(32'(lo_q.size()), 32'h0);
    end_sim;
  end
  // watchdog: all tests need a little over 2 ms
  initial begin
    #2_400_000;
    num_errors++;
    end_sim;
  end
endmodule
